//--- addr_decode_pkg.sv
// package: constants and carriers for the bus slave address decode front end
// ****************************************
// Overview of operation
// ****************************************
// Overview of operation
// - the sixteen received bus lines always follow the multiplexed bus lines, any device.
// - the user input word drives the bus only while all four drive enables are low.
// - drive enables assert only in the data phase of a cycle addressing this device.
// - address bits three to twelve are compared with the ten strapped bits.
// - a full compare in the top bank with bank select set asserts the address match, otherwise it stays low.
// - a grounded strap reads zero and an open strap reads one.
// - only the top io bank with bank select set is answered, at most eight byte addresses, four word registers.
// - the four word addresses are base, base plus 2, base plus 4 and base plus 6.
// - the base ends in octal zero and the other three come from address bits.
// - the match is latched and bits one and two pick exactly one of four selects.
// - bit zero with the byte write flag gives separate high and low byte strobes.
package addr_decode_pkg;
   localparam int DATA_W = 16;
   localparam int STRAP_LO = 3;
   localparam int STRAP_HI = 12;
   localparam int STRAP_W = STRAP_HI - STRAP_LO + 1;
   localparam int REG_SEL_LO = 1;
   localparam int NUM_REGS = 4;
   localparam int NUM_XCVR = 4;
   localparam int BYTE_BIT = 0;
   localparam int BANK_HI = 15;
   localparam int BANK_LO = 13;
   localparam logic [2:0] BANK_TOP = 3'h7;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic sync_n;
      logic din_n;
      logic dout_n;
      logic bank_sel;
      logic write_byte_flag;
   } bus_ctl_t;

   typedef struct packed {
      logic [NUM_REGS-1:0] register_select_lines_n;
      logic input_word_strobe_n;
      logic out_high_byte_strobe_n;
      logic out_low_byte_strobe_n;
   } user_sel_t;
endpackage

//--- bus_slave_address_decode.sv
// module: bus slave address compare, register select and transceiver control
`timescale 1ns/1ps
`default_nettype none
module bus_slave_address_decode (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // backplane side
   input wire logic [addr_decode_pkg::DATA_W-1:0] muxed_address_data_lines_i,
   output logic [addr_decode_pkg::DATA_W-1:0] muxed_address_data_lines_o,
   output logic muxed_address_data_lines_oe_n_o,
   input wire addr_decode_pkg::bus_ctl_t bus_ctl_i,
   // straps, open pins read high
   input wire logic [addr_decode_pkg::STRAP_W-1:0] base_address_straps_i,
   // user side
   output logic [addr_decode_pkg::DATA_W-1:0] received_bus_lines_o,
   input wire logic [addr_decode_pkg::DATA_W-1:0] user_input_word_i,
   output logic address_match_o,
   output logic [addr_decode_pkg::NUM_XCVR-1:0] transceiver_drive_enables_n_o,
   output addr_decode_pkg::user_sel_t user_sel_o
);
   import addr_decode_pkg::*;

   // ****************************************
   // input synchronisers
   // ****************************************
   logic [DATA_W-1:0] muxed_address_data_lines_s1_reg, muxed_address_data_lines_s2_reg;
   bus_ctl_t ctl_s1_reg, ctl_s2_reg, ctl_prev_reg;
   logic [STRAP_W-1:0] strap_s1_reg, strap_s2_reg;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         muxed_address_data_lines_s1_reg <= 16'h0000;
         muxed_address_data_lines_s2_reg <= 16'h0000;
         ctl_s1_reg <= 5'h1e;
         ctl_s2_reg <= 5'h1e;
         ctl_prev_reg <= 5'h1e;
         strap_s1_reg <= 10'h3ff;
         strap_s2_reg <= 10'h3ff;
      end else begin
         muxed_address_data_lines_s1_reg <= muxed_address_data_lines_i;
         muxed_address_data_lines_s2_reg <= muxed_address_data_lines_s1_reg;
         ctl_s1_reg <= bus_ctl_i;
         ctl_s2_reg <= ctl_s1_reg;
         ctl_prev_reg <= ctl_s2_reg;
         strap_s1_reg <= base_address_straps_i;
         strap_s2_reg <= strap_s1_reg;
      end
   end

   // ****************************************
   // address compare
   // ****************************************
   // straps are plain levels here; the pull-up is external so open reads one
   wire [STRAP_W-1:0] addr_bits = muxed_address_data_lines_s2_reg[STRAP_HI:STRAP_LO];
   wire in_top_bank = muxed_address_data_lines_s2_reg[BANK_HI:BANK_LO] == BANK_TOP;
   wire cmp_equal = (addr_bits == strap_s2_reg);
   wire addr_hit = cmp_equal && ctl_s2_reg.bank_sel && in_top_bank;
   wire sync_fall = ctl_prev_reg.sync_n && !ctl_s2_reg.sync_n;
   wire cycle_end = !ctl_prev_reg.sync_n && ctl_s2_reg.sync_n;

   // ****************************************
   // address phase latch
   // ****************************************
   logic match_reg;
   logic [1:0] reg_idx_reg;
   logic byte_addr_reg;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         match_reg <= 1'b0;
         reg_idx_reg <= 2'h0;
         byte_addr_reg <= 1'b0;
      end else if (sync_fall) begin
         match_reg <= addr_hit;
         reg_idx_reg <= muxed_address_data_lines_s2_reg[REG_SEL_LO+1:REG_SEL_LO];
         byte_addr_reg <= muxed_address_data_lines_s2_reg[BYTE_BIT];
      end else if (cycle_end) begin
         match_reg <= 1'b0;
      end
   end

   // ****************************************
   // register select and strobes
   // ****************************************
   wire rd_phase = match_reg && !ctl_s2_reg.sync_n && !ctl_s2_reg.din_n;
   wire wr_phase = match_reg && !ctl_s2_reg.sync_n && !ctl_s2_reg.dout_n;
   wire byte_wr = ctl_s2_reg.write_byte_flag;
   wire hb_wr = wr_phase && (!byte_wr || byte_addr_reg);
   wire lb_wr = wr_phase && (!byte_wr || !byte_addr_reg);

   user_sel_t sel_next, sel_reg;
   logic drive_reg;
   logic [DATA_W-1:0] out_word_reg;

   always_comb begin
      sel_next = '1;
      if (match_reg && !ctl_s2_reg.sync_n) begin
         sel_next.register_select_lines_n[reg_idx_reg] = 1'b0;
      end
      sel_next.input_word_strobe_n = !rd_phase;
      sel_next.out_high_byte_strobe_n = !hb_wr;
      sel_next.out_low_byte_strobe_n = !lb_wr;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sel_reg <= '1;
         drive_reg <= 1'b0;
         out_word_reg <= 16'h0000;
      end else begin
         sel_reg <= sel_next;
         drive_reg <= rd_phase;
         out_word_reg <= user_input_word_i;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // received lines lag the pins by the two synchroniser stages
   assign received_bus_lines_o = muxed_address_data_lines_s2_reg;
   assign address_match_o = match_reg;
   assign user_sel_o = sel_reg;
   assign transceiver_drive_enables_n_o = {NUM_XCVR{!drive_reg}};
   assign muxed_address_data_lines_o = out_word_reg;
   assign muxed_address_data_lines_oe_n_o = !(&(~transceiver_drive_enables_n_o));

   // ****************************************
   // checks
   // ****************************************
   AST_DRIVE_ONLY_ALL_EN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !muxed_address_data_lines_oe_n_o |-> transceiver_drive_enables_n_o == 4'h0)
      else $error("bus driven without all enables");
   AST_DRIVE_NEEDS_MATCH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !transceiver_drive_enables_n_o[0] |-> $past(match_reg) && $past(!ctl_s2_reg.din_n))
      else $error("drive outside an addressed data phase");
   AST_RX_FOLLOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ##2 received_bus_lines_o == $past(muxed_address_data_lines_i, 2))
      else $error("received lines do not follow bus");
   AST_MATCH_CAUSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      sync_fall |=> match_reg == $past(addr_hit))
      else $error("match latch wrong");
   AST_BANK_ONLY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      sync_fall && !ctl_s2_reg.bank_sel |=> !match_reg)
      else $error("match outside top bank");
   AST_CMP_BITS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      addr_hit |-> muxed_address_data_lines_s2_reg[12:3] == strap_s2_reg)
      else $error("compare used wrong bits");
   AST_ONE_SELECT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $countones(~user_sel_o.register_select_lines_n) <= 1)
      else $error("more than one register selected");
   AST_SELECT_INDEX: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      match_reg && !ctl_s2_reg.sync_n |=>
         !user_sel_o.register_select_lines_n[$past(reg_idx_reg)])
      else $error("wrong register selected");
   AST_BYTE_STROBE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wr_phase && byte_wr |=>
         user_sel_o.out_high_byte_strobe_n != user_sel_o.out_low_byte_strobe_n)
      else $error("byte write hit both halves");
   AST_WORD_STROBE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wr_phase && !byte_wr |=>
         !user_sel_o.out_high_byte_strobe_n && !user_sel_o.out_low_byte_strobe_n)
      else $error("word write missed a half");

   // ****************************************
   // sequencing checks
   // ****************************************
   // match must drop at every cycle end, else a stale hit leaks into the next cycle
   AST_MATCH_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cycle_end
      |=> !match_reg)
      else $error("match survived cycle end");
   AST_BANK_ADDR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      sync_fall && !in_top_bank
      |=> !match_reg)
      else $error("match outside top bank address");
   AST_STRAP_MISS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      sync_fall && !cmp_equal
      |=> !match_reg)
      else $error("match despite strap mismatch");
   AST_HIT_SETS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      sync_fall && addr_hit
      |=> match_reg)
      else $error("hit not latched");
   AST_IDX_LATCH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      sync_fall
      |=> reg_idx_reg == $past(muxed_address_data_lines_s2_reg[2:1]))
      else $error("register index not from address bits");
   // straps pass the same two stages as the bus lines
   AST_STRAP_FOLLOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ##2
      strap_s2_reg == $past(base_address_straps_i, 2))
      else $error("strap levels not followed");
   // driven word is the user word one clock late, never a bus echo
   AST_DRIVE_WORD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !muxed_address_data_lines_oe_n_o
      |-> muxed_address_data_lines_o == $past(user_input_word_i))
      else $error("driven word is not the user word");
   AST_EN_EQUAL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      transceiver_drive_enables_n_o == 4'h0
      || transceiver_drive_enables_n_o == 4'hf)
      else $error("drive enables disagree");
   AST_NO_DRIVE_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !match_reg
      |=> transceiver_drive_enables_n_o == 4'hf)
      else $error("drive without match");
   AST_IN_STROBE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rd_phase
      |=> !user_sel_o.input_word_strobe_n && !transceiver_drive_enables_n_o[0])
      else $error("read phase not answered");
   // selects release with sync so the user never sees a select between cycles
   AST_SELECT_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ctl_s2_reg.sync_n
      |=> user_sel_o.register_select_lines_n == 4'hf)
      else $error("select held outside cycle");
   AST_WR_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !wr_phase
      |=> user_sel_o.out_high_byte_strobe_n && user_sel_o.out_low_byte_strobe_n)
      else $error("byte strobe outside write phase");
endmodule
`default_nettype wire

//--- host_model.sv
// host processor model driving the multiplexed backplane
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clk_i,
   output logic [15:0] lines_o,
   output addr_decode_pkg::bus_ctl_t ctl_o
);
   initial {lines_o, ctl_o} = {16'h0000, 5'h1c};
   // address stands 4 clocks before sync falls; the decoder needs none, address and sync pass the same two stages
   task automatic addr(input logic [15:0] a, input logic bs);
      lines_o = a;
      ctl_o.bank_sel = bs;
      repeat (4) @(negedge clk_i);
      ctl_o.sync_n = 1'b0;
      repeat (4) @(negedge clk_i);
   endtask
   // data is the inverse of the address on reads and writes, so a stale address never passes
   task automatic data(input logic rd, input logic wb);
      lines_o = ~lines_o;
      ctl_o.write_byte_flag = wb;
      ctl_o.din_n = ~rd;
      ctl_o.dout_n = rd;
      repeat (4) @(negedge clk_i);
   endtask
   task automatic fin();
      {ctl_o.din_n, ctl_o.dout_n} = 2'h3;
      lines_o = ~lines_o;
      @(negedge clk_i);
      ctl_o.sync_n = 1'b1;
      repeat (4) @(negedge clk_i);
   endtask
endmodule
`default_nettype wire

//--- testbench.sv
// bench: host bus cycles against the address decode front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import addr_decode_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, oe_n, match;
   logic [STRAP_W-1:0] st = 10'h3ff;
   logic [15:0] uw = 16'hc3a5, hl, dl, bus, rx;
   logic [3:0] en_n;
   bus_ctl_t ctl;
   user_sel_t sel;
   int mismatches = 0, n_compared = 0;
   // user side register: take the word on the strobe's leading edge, lines are brief
   logic [15:0] cap = 16'h0000;
   logic wr_q = 1'b0;
   wire wr_s = !sel.out_high_byte_strobe_n || !sel.out_low_byte_strobe_n;
   always @(posedge clk) begin
      wr_q <= wr_s;
      if (wr_s && !wr_q) cap <= rx;
   end
   // device owns the wire only while its enable is low
   assign bus = oe_n ? hl : dl;
   bus_slave_address_decode dut (.clk_i(clk), .rst_n_i(rst_n), .muxed_address_data_lines_i(bus),
      .muxed_address_data_lines_o(dl), .muxed_address_data_lines_oe_n_o(oe_n), .bus_ctl_i(ctl),
      .base_address_straps_i(st), .received_bus_lines_o(rx), .user_input_word_i(uw),
      .address_match_o(match), .transceiver_drive_enables_n_o(en_n), .user_sel_o(sel));
   host_model host (.clk_i(clk), .lines_o(hl), .ctl_o(ctl));
   initial forever #5 clk = ~clk;
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   function automatic logic [15:0] b();
      return {3'h7, st, 3'h0};
   endfunction
   // one whole cycle; a miss must leave every select and enable idle
   task automatic xfer(input logic [15:0] a, input logic bs, rd, wb, hit);
      logic [3:0] s;
      s = hit ? ~(4'h1 << a[2:1]) : 4'hf;
      host.addr(a, bs);
      chk(rx, a);
      chk(16'({match, sel.register_select_lines_n, en_n, oe_n}), 16'({hit, s, 5'h1f}));
      host.data(rd, wb);
      if (rd) begin
         chk(16'({en_n, oe_n, sel.input_word_strobe_n}), hit ? 16'h0000 : 16'h003f);
         chk(bus, hit ? uw : ~a);
      end else begin
         chk(rx, ~a);
         chk(16'({sel.out_high_byte_strobe_n, sel.out_low_byte_strobe_n, en_n, oe_n}),
            16'({~(hit & (~wb | a[0])), ~(hit & (~wb | ~a[0])), 5'h1f}));
      end
      host.fin();
      chk(16'({match, sel, en_n, oe_n}), 16'h0fff);
      if (!rd && hit) chk(cap, ~a);
   endtask
   task automatic rd_regs();
      for (int i = 0; i < 4; i++) xfer(b() + 16'(2 * i), 1'b1, 1'b1, 1'b0, 1'b1);
   endtask
   task automatic wr_strobes();
      for (int k = 0; k < 8; k++) xfer(b() | 16'(k), 1'b1, 1'b0, k[1], 1'b1);
   endtask
   task automatic refusals();
      xfer(b(), 1'b0, 1'b1, 1'b0, 1'b0);
      xfer(b() ^ 16'h2000, 1'b1, 1'b1, 1'b0, 1'b0);
      xfer(b() ^ 16'h0008, 1'b1, 1'b0, 1'b0, 1'b0);
   endtask
   task automatic strap_change();
      st = 10'h000;
      xfer(b() | 16'h0006, 1'b1, 1'b1, 1'b0, 1'b1);
      xfer(16'hfff8, 1'b1, 1'b1, 1'b0, 1'b0);
      st = 10'h2a5;
      xfer(b() | 16'h0002, 1'b1, 1'b0, 1'b1, 1'b1);
   endtask
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      rd_regs();
      wr_strobes();
      refusals();
      strap_change();
      end_sim();
   end
   // a cycle is under 20 clocks, so 20 us leaves ample margin
   initial begin
      #20000;
      mismatches++;
      end_sim();
   end
endmodule
`default_nettype wire
